// [sdpc_consts.svh]
/*
 holds the offsets, field positions, reset values and timing counts of the
 power-state block; assumes it is included by the top module.
*/
`ifndef SDPC_CONSTS_SVH
`define SDPC_CONSTS_SVH
// ****************************************
// register offsets (byte addresses)
// ****************************************
`define SDPC_OFS_CTRL 12'h000
`define SDPC_OFS_STATUS 12'h004
`define SDPC_OFS_ERR 12'h008
`define SDPC_OFS_COUNT 12'h00C
// ****************************************
// fields and reset values
// ****************************************
`define SDPC_CTRL_RST 1'h0
`define SDPC_ERR_RST 4'h0
`define SDPC_STS_BANK_LSB 4
`define SDPC_STS_SLOW_BIT 8
`define SDPC_STS_RDOK_BIT 9
`define SDPC_STS_NROK_BIT 10
`define SDPC_STS_RFC_BIT 11
`define SDPC_ERR_ILLEGAL 0
`define SDPC_ERR_CKE_SHORT 1
`define SDPC_ERR_SR_OPEN 2
`define SDPC_ERR_EARLY_CMD 3
// ****************************************
// timing counts in link clocks, and the mode register slow exit bit
// ****************************************
`define SDPC_XSRD_CLKS 200
`define SDPC_CKE_MIN_CLKS 3
`define SDPC_MR_SLOW_EXIT_BIT 12
`endif

// [sdpc_ctrl_model.sv]
/*
 memory controller model: free-running link clock, clock-enable, command,
 address and termination pins; assumes the bench orders legal steps.
*/
`timescale 1ns/1ns
module sdpc_ctrl_model (
   input wire logic pclk,
   output logic ck,
   output logic cke,
   output logic cs_n,
   output logic ras_n,
   output logic cas_n,
   output logic we_n,
   output logic a10,
   output logic a12,
   output logic [1:0] ba,
   output logic on_die_termination
);
   // ****************************************
   // link clock and pins
   // ****************************************
   initial
   begin
      ck = 1'b0;
      cke = 1'b0;
      {cs_n, ras_n, cas_n, we_n} = 4'hF;
      {a12, a10} = 2'h0;
      ba = 2'h0;
      on_die_termination = 1'b0; // always driven, also in power-down
   end
   // keeps running through power-down and self refresh
   // period never changes: no frequency change, relock or recovery reload
   // cke only drops with no burst, mode load or precharge in flight
   always
   begin
      #63 ck = 1'b1;
      #62 ck = 1'b0;
   end
   // ****************************************
   // one command per rising edge
   // ****************************************
   task automatic step(input logic c, input logic [3:0] cmd, input logic [1:0] adr,
                       input logic [1:0] b);
      @(negedge ck);
      cke = c; // caller holds each level three edges
      {cs_n, ras_n, cas_n, we_n} = cmd; // nop or deselect on cke edges, or refresh when cke drops
      {a12, a10} = adr;
      ba = cmd[3] ? ~b : b; // address is junk while deselected
      @(posedge ck);
      repeat (6) @(posedge pclk);
      {cs_n, ras_n, cas_n, we_n} = 4'hF;
   endtask : step
endmodule : sdpc_ctrl_model

// [sdpc_if.sv]
/*
 holds the carrier between the pin sampler and the power-state core; assumes
 both ends run on pclk.
*/
`timescale 1ns/1ns
interface sdpc_if #(parameter int BA_W = 2);
   logic ck_rise;
   logic cke;
   sdpc_pkg::sdpc_cmd_t cmd;
   logic a10;
   logic a12;
   logic [BA_W-1:0] ba;
   logic on_die_termination;
   modport samp (output ck_rise, output cke, output cmd, output a10, output a12, output ba,
                 output on_die_termination);
   modport core (input ck_rise, input cke, input cmd, input a10, input a12, input ba, input on_die_termination);
endinterface : sdpc_if

// [sdpc_pkg.sv]
/*
 holds the state and command types of the power-state block; assumes the
 four command pins are already synchronised when decoded.
*/
package sdpc_pkg;
   typedef enum logic [2:0] {st_idle, st_active, st_pre_pd, st_act_pd, st_self_ref} sdpc_state_t;
   typedef enum logic [3:0] {cmd_lm, cmd_ref, cmd_pre, cmd_act, cmd_wr, cmd_rd, cmd_nop,
                             cmd_desel, cmd_rsvd} sdpc_cmd_t;

   function automatic sdpc_cmd_t decode(input logic [3:0] pins);
      sdpc_cmd_t c;
      c = cmd_rsvd;
      if (pins[3])
      begin
         c = cmd_desel;
      end
      else
      begin
         unique case (pins[2:0])
            3'h0: c = cmd_lm;
            3'h1: c = cmd_ref;
            3'h2: c = cmd_pre;
            3'h3: c = cmd_act;
            3'h4: c = cmd_wr;
            3'h5: c = cmd_rd;
            3'h7: c = cmd_nop;
            default: c = cmd_rsvd;
         endcase
      end
      return c;
   endfunction : decode
endpackage : sdpc_pkg

// [sdpc_sampler.sv]
/*
 holds the pin sampler: two flip-flops on every pin, then link clock edge
 detection; assumes the pins are asynchronous to pclk and the link clock is
 well below half the pclk rate.
*/
`timescale 1ns/1ns
module sdpc_sampler #(parameter int BA_W = 2) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [BA_W+8:0] pins,
   sdpc_if.samp lk
);
   localparam int W = BA_W + 9;
   logic [W-1:0] s1_reg, s1_next, s2_reg, s2_next;
   logic ck_d_reg, ck_d_next;

   always_comb
   begin
      s1_next = pins;
      s2_next = s1_reg;
      ck_d_next = s2_reg[0];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s1_reg <= '0;
         s2_reg <= '0;
         ck_d_reg <= 1'b0;
      end
      else
      begin
         s1_reg <= s1_next;
         s2_reg <= s2_next;
         ck_d_reg <= ck_d_next;
      end
   end

   // pins: ck, cke, cs_n ras_n cas_n we_n, a10, a12, odt, ba
   assign lk.ck_rise = s2_reg[0] & ~ck_d_reg;
   assign lk.cke = s2_reg[1];
   assign lk.cmd = sdpc_pkg::decode(s2_reg[5:2]);
   assign lk.a10 = s2_reg[6];
   assign lk.a12 = s2_reg[7];
   assign lk.on_die_termination = s2_reg[8];
   assign lk.ba = s2_reg[W-1:9];
endmodule : sdpc_sampler

// [sdpc_top.sv]
/*
 holds the power-state core of the memory device: clock-enable truth table,
 bank tracking, exit delays and an APB register slave; assumes the link pins
 come from a controller on another clock and APB runs on pclk.
*/
`timescale 1ns/1ns
`include "sdpc_consts.svh"
module sdpc_top #(
   parameter int NUM_BANKS = 4,
   parameter int XSNR_CLKS = 10,
   parameter int XP_CLKS = 2,
   parameter int XARD_CLKS = 2,
   parameter int XARDS_CLKS = 7,
   parameter int RFC_CLKS = 20
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ck,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic a10,
   input wire logic a12,
   input wire logic [$clog2(NUM_BANKS)-1:0] ba,
   input wire logic on_die_termination,
   output logic [2:0] power_state,
   output logic self_refresh,
   output logic termination_on,
   output logic refresh_busy,
   output logic read_allowed,
   output logic nonread_allowed
);
   localparam int BA_W = $clog2(NUM_BANKS);
   typedef sdpc_pkg::sdpc_state_t st_t;

   sdpc_if #(.BA_W(BA_W)) lk ();

   sdpc_sampler #(.BA_W(BA_W)) u_samp (
      .pclk(pclk),
      .presetn(presetn),
      .pins({ba, on_die_termination, a12, a10, cs_n, ras_n, cas_n, we_n, cke, ck}),
      .lk(lk)
   );

   // ****************************************
   // link side state
   // ****************************************
   st_t state_reg, state_next;
   logic cke_prev_reg, cke_prev_next;
   logic [NUM_BANKS-1:0] bank_open_reg, bank_open_next;
   logic slow_exit_reg, slow_exit_next;
   logic [1:0] run_reg, run_next;
   logic [7:0] xs_cnt_reg, xs_cnt_next;
   logic [7:0] rd_tgt_reg, rd_tgt_next;
   logic [7:0] nr_tgt_reg, nr_tgt_next;
   logic [7:0] rfc_reg, rfc_next;
   logic [3:0] err_reg, err_next;
   logic term_reg, term_next;
   logic [3:0] err_set;
   logic [3:0] err_clr;
   logic ctrl_reg, ctrl_next;
   logic is_nop, any_open;

   assign is_nop = (lk.cmd == sdpc_pkg::cmd_nop) || (lk.cmd == sdpc_pkg::cmd_desel);
   assign any_open = |bank_open_reg;

   always_comb
   begin
      state_next = state_reg;
      cke_prev_next = cke_prev_reg;
      bank_open_next = bank_open_reg;
      slow_exit_next = slow_exit_reg;
      run_next = run_reg;
      xs_cnt_next = xs_cnt_reg;
      rd_tgt_next = rd_tgt_reg;
      nr_tgt_next = nr_tgt_reg;
      rfc_next = rfc_reg;
      err_set = 4'h0;
      if (lk.ck_rise)
      begin
         cke_prev_next = lk.cke;
         if (lk.cke == cke_prev_reg)
         begin
            if (run_reg != 2'(`SDPC_CKE_MIN_CLKS))
            begin
               run_next = run_reg + 2'h1;
            end
         end
         else
         begin
            // level changed before three registrations at the old level
            err_set[`SDPC_ERR_CKE_SHORT] = (run_reg < 2'(`SDPC_CKE_MIN_CLKS));
            run_next = 2'h1;
         end
         if (xs_cnt_reg != 8'hFF)
         begin
            xs_cnt_next = xs_cnt_reg + 8'h01;
         end
         // refresh completes internally, also after power-down entry
         if (rfc_reg != 8'h00)
         begin
            rfc_next = rfc_reg - 8'h01;
         end
         unique case (state_reg)
            sdpc_pkg::st_pre_pd, sdpc_pkg::st_act_pd:
            begin
               if (lk.cke)
               begin
                  err_set[`SDPC_ERR_ILLEGAL] = !is_nop;
                  state_next = any_open ? sdpc_pkg::st_active : sdpc_pkg::st_idle;
                  xs_cnt_next = 8'h00;
                  nr_tgt_next = 8'(XP_CLKS);
                  if (state_reg == sdpc_pkg::st_act_pd)
                  begin
                     rd_tgt_next = slow_exit_reg ? 8'(XARDS_CLKS) : 8'(XARD_CLKS);
                  end
                  else
                  begin
                     rd_tgt_next = 8'(XP_CLKS);
                  end
               end
            end
            sdpc_pkg::st_self_ref:
            begin
               if (lk.cke)
               begin
                  err_set[`SDPC_ERR_ILLEGAL] = !is_nop;
                  state_next = sdpc_pkg::st_idle;
                  xs_cnt_next = 8'h00;
                  nr_tgt_next = 8'(XSNR_CLKS);
                  rd_tgt_next = 8'(`SDPC_XSRD_CLKS);
               end
            end
            sdpc_pkg::st_idle, sdpc_pkg::st_active:
            begin
               if (!lk.cke && cke_prev_reg)
               begin
                  if (is_nop)
                  begin
                     state_next = any_open ? sdpc_pkg::st_act_pd : sdpc_pkg::st_pre_pd;
                  end
                  else if (lk.cmd == sdpc_pkg::cmd_ref && !any_open)
                  begin
                     state_next = sdpc_pkg::st_self_ref;
                  end
                  else if (lk.cmd == sdpc_pkg::cmd_ref)
                  begin
                     err_set[`SDPC_ERR_SR_OPEN] = 1'b1;
                  end
                  else
                  begin
                     err_set[`SDPC_ERR_ILLEGAL] = 1'b1;
                  end
               end
               else if (lk.cke)
               begin
                  if (lk.cmd == sdpc_pkg::cmd_rd)
                  begin
                     err_set[`SDPC_ERR_EARLY_CMD] = (xs_cnt_reg < rd_tgt_reg);
                  end
                  else if (!is_nop)
                  begin
                     err_set[`SDPC_ERR_EARLY_CMD] = (xs_cnt_reg < nr_tgt_reg);
                  end
                  unique case (lk.cmd)
                     sdpc_pkg::cmd_act: bank_open_next[lk.ba] = 1'b1;
                     sdpc_pkg::cmd_pre:
                     begin
                        if (lk.a10)
                        begin
                           bank_open_next = '0;
                        end
                        else
                        begin
                           bank_open_next[lk.ba] = 1'b0;
                        end
                     end
                     sdpc_pkg::cmd_wr:
                     begin
                        // auto precharge closes this bank's row; with no other bank open, entry lands in precharge pd
                        if (lk.a10)
                        begin
                           bank_open_next[lk.ba] = 1'b0;
                        end
                     end
                     sdpc_pkg::cmd_ref: rfc_next = 8'(RFC_CLKS);
                     sdpc_pkg::cmd_lm:
                     begin
                        if (lk.ba == '0)
                        begin
                           slow_exit_next = lk.a12;
                        end
                     end
                     default:
                     begin
                     end
                  endcase
               end
            end
         endcase
         if (state_next == sdpc_pkg::st_idle || state_next == sdpc_pkg::st_active)
         begin
            state_next = (|bank_open_next) ? sdpc_pkg::st_active : sdpc_pkg::st_idle;
         end
      end
      // a new event wins over a clear in the same cycle
      err_next = (err_reg & ~err_clr) | err_set;
      // termination input has no effect on the state; off in self refresh
      term_next = lk.on_die_termination & ctrl_reg & (state_next != sdpc_pkg::st_self_ref);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg <= sdpc_pkg::st_idle;
         cke_prev_reg <= 1'b0;
         bank_open_reg <= '0;
         slow_exit_reg <= 1'b0;
         run_reg <= 2'h0;
         xs_cnt_reg <= 8'hFF;
         rd_tgt_reg <= 8'h00;
         nr_tgt_reg <= 8'h00;
         rfc_reg <= 8'h00;
         err_reg <= `SDPC_ERR_RST;
         term_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         cke_prev_reg <= cke_prev_next;
         bank_open_reg <= bank_open_next;
         slow_exit_reg <= slow_exit_next;
         run_reg <= run_next;
         xs_cnt_reg <= xs_cnt_next;
         rd_tgt_reg <= rd_tgt_next;
         nr_tgt_reg <= nr_tgt_next;
         rfc_reg <= rfc_next;
         err_reg <= err_next;
         term_reg <= term_next;
      end
   end

   assign power_state = 3'(state_reg);
   assign self_refresh = (state_reg == sdpc_pkg::st_self_ref);
   assign termination_on = term_reg;
   assign refresh_busy = (rfc_reg != 8'h00);
   assign read_allowed = (xs_cnt_reg >= rd_tgt_reg);
   assign nonread_allowed = (xs_cnt_reg >= nr_tgt_reg);

   // ****************************************
   // apb slave
   // ****************************************
   logic [31:0] prdata_reg, prdata_next;
   logic hit;
   logic [31:0] rd_mux;

   always_comb
   begin
      hit = 1'b1;
      rd_mux = 32'h0000_0000;
      unique case (paddr)
         `SDPC_OFS_CTRL: rd_mux = {31'h0000_0000, ctrl_reg};
         `SDPC_OFS_STATUS:
         begin
            rd_mux[2:0] = power_state;
            rd_mux[`SDPC_STS_BANK_LSB +: NUM_BANKS] = bank_open_reg;
            rd_mux[`SDPC_STS_SLOW_BIT] = slow_exit_reg;
            rd_mux[`SDPC_STS_RDOK_BIT] = read_allowed;
            rd_mux[`SDPC_STS_NROK_BIT] = nonread_allowed;
            rd_mux[`SDPC_STS_RFC_BIT] = refresh_busy;
         end
         `SDPC_OFS_ERR: rd_mux = {28'h000_0000, err_reg};
         `SDPC_OFS_COUNT: rd_mux = {16'h0000, rfc_reg, xs_cnt_reg};
         default: hit = 1'b0;
      endcase
      prdata_next = prdata_reg;
      if (psel && !penable)
      begin
         prdata_next = pwrite ? 32'h0000_0000 : rd_mux;
      end
      ctrl_next = ctrl_reg;
      err_clr = 4'h0;
      if (psel && penable && pwrite && paddr == `SDPC_OFS_CTRL)
      begin
         ctrl_next = pwdata[0];
      end
      if (psel && penable && pwrite && paddr == `SDPC_OFS_ERR)
      begin
         err_clr = pwdata[3:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_reg <= 32'h0000_0000;
         ctrl_reg <= `SDPC_CTRL_RST;
      end
      else
      begin
         prdata_reg <= prdata_next;
         ctrl_reg <= ctrl_next;
      end
   end

   assign prdata = prdata_reg;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~hit;

   // ****************************************
   // checks
   // ****************************************
   logic [8:0] sr_edges_reg;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sr_edges_reg <= 9'h000;
      end
      else if (self_refresh)
      begin
         sr_edges_reg <= 9'h000;
      end
      else if (lk.ck_rise && sr_edges_reg != 9'h1FF)
      begin
         sr_edges_reg <= sr_edges_reg + 9'h001;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_cke_level_kept: assert property (lk.ck_rise |=> cke_prev_reg == $past(lk.cke))
      else $error("previous cke level not registered");
   a_sr_entry_cause: assert property ($rose(self_refresh) |-> $past(lk.ck_rise && !lk.cke
      && lk.cmd == sdpc_pkg::cmd_ref && bank_open_reg == '0))
      else $error("self refresh entered without refresh and idle banks");
   a_pd_mode_pick: assert property (lk.ck_rise && !lk.cke && cke_prev_reg && is_nop
      && !self_refresh && state_reg != sdpc_pkg::st_pre_pd && state_reg != sdpc_pkg::st_act_pd
      |=> state_reg == ($past(any_open) ? sdpc_pkg::st_act_pd : sdpc_pkg::st_pre_pd))
      else $error("wrong power-down mode chosen");
   a_no_refresh_pd: assert property ((state_reg == sdpc_pkg::st_pre_pd
      || state_reg == sdpc_pkg::st_act_pd) |=> !(rfc_reg > $past(rfc_reg)))
      else $error("refresh started in power-down");
   a_read_gate_sr: assert property ($rose(read_allowed) && rd_tgt_reg == 8'(`SDPC_XSRD_CLKS)
      |-> sr_edges_reg >= 9'(`SDPC_XSRD_CLKS))
      else $error("read allowed too early after self refresh");
   a_cke_short_flag: assert property (lk.ck_rise && lk.cke != cke_prev_reg && run_reg < 2'h3
      |=> err_reg[`SDPC_ERR_CKE_SHORT])
      else $error("short cke pulse not flagged");
   a_term_off_sr: assert property (self_refresh |-> !termination_on)
      else $error("termination on in self refresh");
   a_rfc_runs_pd: assert property (refresh_busy && lk.ck_rise
      |=> rfc_reg == $past(rfc_reg) - 8'h01)
      else $error("refresh timer stalled");
   a_exit_delay_sel: assert property (lk.ck_rise && state_reg == sdpc_pkg::st_act_pd && lk.cke
      |=> rd_tgt_reg == ($past(slow_exit_reg) ? 8'(XARDS_CLKS) : 8'(XARD_CLKS)))
      else $error("wrong active power-down exit delay");

   c_pre_pd: cover property ($rose(state_reg == sdpc_pkg::st_pre_pd));
   c_act_pd: cover property ($rose(state_reg == sdpc_pkg::st_act_pd));
   c_sr_entry: cover property ($rose(self_refresh));
   c_sr_read_ok: cover property ($rose(read_allowed) && rd_tgt_reg == 8'(`SDPC_XSRD_CLKS));
endmodule : sdpc_top

// [sdram_power_state_control_test.sv]
/*
 self-checking bench of the power-state block: reset case, table of pin steps,
 then exit-delay, register and refusal cases; assumes pclk at 125 MHz.
*/
`timescale 1ns/1ns
module sdram_power_state_control_test;
   typedef struct packed {
      logic cke;
      logic [3:0] cmd;
      logic [1:0] adr;
      logic [1:0] ba;
      logic [3:0] n;
      logic [2:0] st;
      logic rb;
   } sdpc_row_t;
   localparam logic [3:0] c_lm = 4'h0;
   localparam logic [3:0] c_ref = 4'h1;
   localparam logic [3:0] c_pre = 4'h2;
   localparam logic [3:0] c_act = 4'h3;
   localparam logic [3:0] c_wr = 4'h4;
   localparam logic [3:0] c_nop = 4'h7;
   localparam logic [3:0] c_des = 4'hF;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd;
   logic pready, pslverr, er;
   logic ck, cke, cs_n, ras_n, cas_n, we_n, a10, a12, on_die_termination;
   logic [1:0] ba;
   logic [2:0] power_state;
   logic self_refresh, termination_on, refresh_busy, read_allowed, nonread_allowed;
   int errors = 0;
   int total_checks = 0;
   // ****************************************
   // pin step table
   // ****************************************
   sdpc_row_t rows [15] = '{
      '{1'b1, c_nop, 2'h0, 2'h0, 4'h3, 3'h0, 1'b0},
      '{1'b1, c_act, 2'h0, 2'h1, 4'h1, 3'h1, 1'b0},
      '{1'b0, c_nop, 2'h0, 2'h0, 4'h3, 3'h3, 1'b0},
      '{1'b1, c_des, 2'h0, 2'h0, 4'h3, 3'h1, 1'b0},
      '{1'b1, c_pre, 2'h1, 2'h0, 4'h1, 3'h0, 1'b0},
      '{1'b1, c_act, 2'h0, 2'h0, 4'h1, 3'h1, 1'b0},
      '{1'b1, c_wr, 2'h1, 2'h0, 4'h1, 3'h0, 1'b0},
      '{1'b0, c_des, 2'h0, 2'h0, 4'h3, 3'h2, 1'b0},
      '{1'b1, c_nop, 2'h0, 2'h0, 4'h3, 3'h0, 1'b0},
      '{1'b1, c_ref, 2'h0, 2'h0, 4'h1, 3'h0, 1'b1},
      '{1'b0, c_nop, 2'h0, 2'h0, 4'h1, 3'h2, 1'b1},
      '{1'b0, c_nop, 2'h0, 2'h0, 4'h6, 3'h2, 1'b0},
      '{1'b1, c_nop, 2'h0, 2'h0, 4'h3, 3'h0, 1'b0},
      '{1'b0, c_ref, 2'h0, 2'h0, 4'h1, 3'h4, 1'b0},
      '{1'b0, c_nop, 2'h0, 2'h0, 4'h2, 3'h4, 1'b0}
   };
   always #4 pclk = ~pclk;
   sdpc_top #(.XSNR_CLKS(4), .RFC_CLKS(5)) dut (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
      .cas_n(cas_n), .we_n(we_n), .a10(a10), .a12(a12), .ba(ba), .on_die_termination(on_die_termination),
      .power_state(power_state), .self_refresh(self_refresh),
      .termination_on(termination_on), .refresh_busy(refresh_busy),
      .read_allowed(read_allowed), .nonread_allowed(nonread_allowed));
   sdpc_ctrl_model m (
      .pclk(pclk), .ck(ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
      .we_n(we_n), .a10(a10), .a12(a12), .ba(ba), .on_die_termination(on_die_termination));
   // ****************************************
   // tasks
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 16);
      psel <= 1'b0;
      penable <= 1'b0;
      if (k < 16)
      begin
         rd = prdata;
         er = pslverr;
      end
      else
      begin
         errors++;
         print_verdict();
      end
   endtask : apb
   task automatic steps(input int n, input logic c, input logic [3:0] cmd);
      repeat (n) m.step(c, cmd, 2'h0, 2'h0);
   endtask : steps
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
      begin
         $display("RESULT: PASS");
      end
      else
      begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : print_verdict
   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk({power_state, termination_on, refresh_busy, read_allowed, nonread_allowed}, 7'h03);
      apb(1'b0, 12'h000, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      $display("test reset done");
      steps(3, 1'b0, c_nop);
      apb(1'b1, 12'h000, 32'h0000_0001);
      apb(1'b0, 12'h000, 32'h0000_0000);
      chk(rd, 32'h0000_0001);
      m.on_die_termination = 1'b1;
      foreach (rows[i])
      begin
         for (int j = 0; j < rows[i].n; j++)
         begin
            m.step(rows[i].cke, rows[i].cmd, rows[i].adr, rows[i].ba);
         end
         chk({power_state, self_refresh, refresh_busy, termination_on},
             {rows[i].st, rows[i].st == 3'h4, rows[i].rb, rows[i].st != 3'h4});
      end
      apb(1'b0, 12'h004, 32'h0000_0000);
      chk(rd[2:0], 3'h4);
      $display("test table done");
      steps(1, 1'b1, c_nop);
      chk({power_state, nonread_allowed, read_allowed}, 5'h00);
      steps(9, 1'b1, c_nop);
      chk({nonread_allowed, read_allowed}, 2'b10);
      steps(185, 1'b1, c_nop);
      chk(read_allowed, 1'b0);
      steps(10, 1'b1, c_nop);
      chk(read_allowed, 1'b1);
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      $display("test self refresh exit done");
      m.step(1'b1, c_lm, 2'h2, 2'h0);
      steps(3, 1'b1, c_nop);
      m.step(1'b1, c_act, 2'h0, 2'h2);
      apb(1'b0, 12'h004, 32'h0000_0000);
      chk({rd[8], rd[7:4]}, 5'h14);
      steps(3, 1'b0, c_nop);
      chk(power_state, 3'h3);
      steps(4, 1'b1, c_nop);
      chk({nonread_allowed, read_allowed}, 2'b10);
      steps(6, 1'b1, c_nop);
      chk(read_allowed, 1'b1);
      $display("test slow exit done");
      m.step(1'b0, c_ref, 2'h0, 2'h0);
      chk(power_state, 3'h1);
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk(rd[2], 1'b1);
      apb(1'b1, 12'h008, 32'h0000_0004);
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk(rd[2], 1'b0);
      apb(1'b0, 12'h010, 32'h0000_0000);
      chk({er, rd[30:0]}, 32'h8000_0000);
      $display("test refusals done");
      print_verdict();
   end
endmodule : sdram_power_state_control_test
